/* File: rtl/fcc_pkg.sv */
// Package with register map, field layout, reset values and timing of the fan controller configuration bank.

package fcc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_IDX = 8'h04;
	localparam logic [7:0] ALARM_FAN_CONFIG_IDX   = 8'h3F;
	localparam logic [7:0] FAN_SPEED_READING_IDX  = 8'h20;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int FULL_SPEED_ON_ALARM_BIT = 7;
	localparam int REVISION_MSB            = 3;
	localparam int SETUP_MODE_BIT          = 7;
	localparam int PULSES_PER_REV_BIT      = 6;
	localparam int FAST_SPEED_UPDATE_BIT   = 5;
	localparam int OVERTEMP_PIN_EN_BIT     = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset and fixed values.
	localparam logic [7:0] FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_RST  = 8'h08;
	localparam logic       FULL_SPEED_ON_ALARM_RST = 1'h1;
	// The revision value is arbitrary and names no real part.
	localparam logic [3:0] REVISION_DEFAULT        = 4'h5;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int PCLK_HZ          = 125000000;
	localparam int FAST_UPDATE_MS   = 250;
	localparam int SLOW_UPDATE_MS   = 1000;
	localparam int FAST_UPDATE_CYC  = FAST_UPDATE_MS * (PCLK_HZ / 1000);
	localparam int SLOW_UPDATE_CYC  = SLOW_UPDATE_MS * (PCLK_HZ / 1000);
	localparam int RELEASE_SETTLE   = 3;
	localparam int SECONDS_PER_MIN  = 60;
	localparam int FAST_PER_SECOND  = 4;

endpackage : fcc_pkg

/* File: rtl/fcc_fan_speed_pulse_input_meter.sv */
// Fan_speed_pulse_input pulse counter that turns pulses per update period into a speed reading in revolutions per minute.
`timescale 1ns/1ps

module fcc_fan_speed_pulse_input_meter #(
	parameter int FAST_CYC = fcc_pkg::FAST_UPDATE_CYC,
	parameter int SLOW_CYC = fcc_pkg::SLOW_UPDATE_CYC
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Control.
	input  wire logic        pulse,
	input  wire logic        four_pulses,
	input  wire logic        fast_update,
	// Result.
	output logic      [15:0] reading,
	output logic             update
);

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [26:0] timer;
		logic [15:0] pulses;
		logic [15:0] reading;
		logic        update;
	} fcc_fan_speed_pulse_input_state_t;

	fcc_fan_speed_pulse_input_state_t state;
	fcc_fan_speed_pulse_input_state_t next_state;

	logic [26:0] period_last;
	logic [15:0] revs;
	logic [31:0] rpm;

	always_comb begin
		next_state = state;
		next_state.update = 1'b0;
		period_last = fast_update ? 27'(FAST_CYC - 1) : 27'(SLOW_CYC - 1);
		revs = four_pulses ? (state.pulses >> 2) : (state.pulses >> 1);
		// Scale to a minute so that both update rates give the same unit.
		if (fast_update) begin
			rpm = 32'(revs) * 32'(fcc_pkg::SECONDS_PER_MIN * fcc_pkg::FAST_PER_SECOND);
		end else begin
			rpm = 32'(revs) * 32'(fcc_pkg::SECONDS_PER_MIN);
		end
		if (state.timer >= period_last) begin
			next_state.timer = '0;
			next_state.pulses = {15'h0000, pulse};
			next_state.reading = (rpm > 32'h0000FFFF) ? 16'hFFFF : rpm[15:0];
			next_state.update = 1'b1;
		end else begin
			next_state.timer = state.timer + 27'h0000001;
			if (pulse && state.pulses != 16'hFFFF) begin
				next_state.pulses = state.pulses + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign reading = state.reading;
	assign update = state.update;

endmodule // fcc_fan_speed_pulse_input_meter

/* File: rtl/fcc_config_regs.sv */
// Configuration register bank of the fan controller with APB access, alarm pin handling and fan_speed_pulse_input speed reading.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

module fcc_config_regs #(
	parameter int FAST_CYC = fcc_pkg::FAST_UPDATE_CYC,
	parameter int SLOW_CYC = fcc_pkg::SLOW_UPDATE_CYC,
	// Arbitrary revision value.
	parameter logic [3:0] REVISION = fcc_pkg::REVISION_DEFAULT
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic  [7:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic  [3:0] pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Thermal alarm pin, two-way and open drain.
	input  wire logic        thermal_alarm_pin_i,
	output logic             thermal_alarm_pin_o,
	output logic             thermal_alarm_pin_oe,
	// Overtemp output pin, active low.
	output logic             overtemp_output_pin_n_o,
	output logic             overtemp_output_pin_n_oe,
	// Fan fan_speed_pulse_input pulse pin.
	input  wire logic        fan_speed_pulse_input,
	// Monitor and fan control side.
	input  wire logic        alarm_request,
	input  wire logic        overtemp_condition,
	output logic             fan_full_speed,
	output logic             setup_mode,
	output logic      [15:0] fan_speed_reading,
	output logic             fan_speed_update
);

	////////////////////////////////////////////////////////////////////////////////
	// State of the bank, apart from the speed meter's own registers.
	typedef struct packed {
		logic        full_speed_on_alarm_enable;
		logic        setup_mode;
		logic        pulses_per_rev_bit;
		logic        fast_speed_update;
		logic        overtemp_pin_enable;
		logic [31:0] rdata;
		logic        slverr;
		logic        fan_speed_pulse_input_s1;
		logic        fan_speed_pulse_input_s2;
		logic        fan_speed_pulse_input_prev;
		logic        alarm_s1;
		logic        alarm_s2;
		logic        drive_alarm;
		logic  [1:0] release_cnt;
		logic        full_speed;
		logic        overtemp_n;
	} fcc_regs_state_t;

	fcc_regs_state_t state;
	fcc_regs_state_t next_state;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and read-back values.
	logic        setup_phase;
	logic        access_write;
	logic        hit_fan_speed_pulse_input_cfg;
	logic        hit_alarm_cfg;
	logic        hit_speed;
	logic  [7:0] fan_speed_pulse_input_cfg_value;
	logic  [7:0] alarm_cfg_value;
	logic        fan_speed_pulse_input_pulse;
	logic        external_low;
	logic [15:0] meter_reading;
	logic        meter_update;

	assign setup_phase   = psel && !penable;
	assign access_write  = psel && penable && pwrite;
	assign hit_fan_speed_pulse_input_cfg  = paddr == {fcc_pkg::FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_IDX[5:0], 2'b00};
	assign hit_alarm_cfg = paddr == {fcc_pkg::ALARM_FAN_CONFIG_IDX[5:0], 2'b00};
	assign hit_speed     = paddr == {fcc_pkg::FAN_SPEED_READING_IDX[5:0], 2'b00};

	// Reserved bits are constants in the read path, so no write can reach them.
	always_comb begin
		fan_speed_pulse_input_cfg_value = fcc_pkg::FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_RST;
		fan_speed_pulse_input_cfg_value[fcc_pkg::SETUP_MODE_BIT] = state.setup_mode;
		fan_speed_pulse_input_cfg_value[fcc_pkg::PULSES_PER_REV_BIT] = state.pulses_per_rev_bit;
		fan_speed_pulse_input_cfg_value[fcc_pkg::FAST_SPEED_UPDATE_BIT] = state.fast_speed_update;
		fan_speed_pulse_input_cfg_value[fcc_pkg::OVERTEMP_PIN_EN_BIT] = state.overtemp_pin_enable;
		alarm_cfg_value = {state.full_speed_on_alarm_enable, 3'b000, REVISION};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin edge detection; the second stage is compared with the prev stage that follows it.
	assign fan_speed_pulse_input_pulse = state.fan_speed_pulse_input_s2 && !state.fan_speed_pulse_input_prev;

	// The synchronised pin lags the driver, so an outside low is only believed once our own
	// drive has been released for long enough to have left the synchroniser.
	assign external_low = !state.alarm_s2 && !state.drive_alarm &&
		state.release_cnt == 2'(fcc_pkg::RELEASE_SETTLE);

	fcc_fan_speed_pulse_input_meter #(
		.FAST_CYC    (FAST_CYC),
		.SLOW_CYC    (SLOW_CYC)
	) u_fan_speed_pulse_input_meter (
		.pclk        (pclk),
		.presetn     (presetn),
		.pulse       (fan_speed_pulse_input_pulse),
		.four_pulses (state.pulses_per_rev_bit),
		.fast_update (state.fast_speed_update),
		.reading     (meter_reading),
		.update      (meter_update)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		next_state = state;

		next_state.fan_speed_pulse_input_s1 = fan_speed_pulse_input;
		next_state.fan_speed_pulse_input_s2 = state.fan_speed_pulse_input_s1;
		next_state.fan_speed_pulse_input_prev = state.fan_speed_pulse_input_s2;
		next_state.alarm_s1 = thermal_alarm_pin_i;
		next_state.alarm_s2 = state.alarm_s1;

		next_state.drive_alarm = alarm_request;
		if (state.drive_alarm) begin
			next_state.release_cnt = '0;
		end else if (state.release_cnt != 2'(fcc_pkg::RELEASE_SETTLE)) begin
			next_state.release_cnt = state.release_cnt + 2'b01;
		end

		// Own drive gates on the enable; an outside pull wins only once our own drive is released and settled.
		next_state.full_speed = (state.drive_alarm && state.full_speed_on_alarm_enable) ||
			external_low;

		next_state.overtemp_n = !overtemp_condition;

		// Read data is captured in the setup cycle and shown in the access cycle.
		if (setup_phase) begin
			next_state.rdata = '0;
			next_state.slverr = 1'b0;
			if (hit_fan_speed_pulse_input_cfg) begin
				next_state.rdata = {24'h000000, fan_speed_pulse_input_cfg_value};
			end else if (hit_alarm_cfg) begin
				next_state.rdata = {24'h000000, alarm_cfg_value};
			end else if (hit_speed) begin
				next_state.rdata = {16'h0000, meter_reading};
			end else begin
				next_state.slverr = 1'b1;
			end
		end

		// Only writable bits are stored; reserved positions of pwdata are dropped.
		if (access_write && pstrb[0]) begin
			if (hit_fan_speed_pulse_input_cfg) begin
				next_state.setup_mode = pwdata[fcc_pkg::SETUP_MODE_BIT];
				next_state.pulses_per_rev_bit = pwdata[fcc_pkg::PULSES_PER_REV_BIT];
				next_state.fast_speed_update = pwdata[fcc_pkg::FAST_SPEED_UPDATE_BIT];
				next_state.overtemp_pin_enable = pwdata[fcc_pkg::OVERTEMP_PIN_EN_BIT];
			end else if (hit_alarm_cfg) begin
				next_state.full_speed_on_alarm_enable = pwdata[fcc_pkg::FULL_SPEED_ON_ALARM_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
			state.setup_mode <= fcc_pkg::FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_RST[fcc_pkg::SETUP_MODE_BIT];
			state.pulses_per_rev_bit <= fcc_pkg::FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_RST[fcc_pkg::PULSES_PER_REV_BIT];
			state.fast_speed_update <= fcc_pkg::FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_RST[fcc_pkg::FAST_SPEED_UPDATE_BIT];
			state.overtemp_pin_enable <= fcc_pkg::FAN_SPEED_PULSE_INPUT_OUTPUT_CONFIG_RST[fcc_pkg::OVERTEMP_PIN_EN_BIT];
			state.full_speed_on_alarm_enable <= fcc_pkg::FULL_SPEED_ON_ALARM_RST;
			state.fan_speed_pulse_input_s1 <= 1'b0;
			state.alarm_s1 <= 1'b1;
			state.alarm_s2 <= 1'b1;
			state.overtemp_n <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign pready  = psel && penable;
	assign prdata  = state.rdata;
	assign pslverr = psel && penable && state.slverr;

	assign thermal_alarm_pin_o  = 1'b0;
	assign thermal_alarm_pin_oe = state.drive_alarm;

	assign overtemp_output_pin_n_o  = state.overtemp_n;
	assign overtemp_output_pin_n_oe = state.overtemp_pin_enable;

	assign fan_full_speed    = state.full_speed;
	assign setup_mode        = state.setup_mode;
	assign fan_speed_reading = meter_reading;
	assign fan_speed_update  = meter_update;

endmodule // fcc_config_regs

/* File: verif/fcc_apb_host.sv */
// Host model that drives register transfers into the configuration bank over APB.
`timescale 1ns/1ps

module fcc_apb_host (
	// Clock.
	input  wire logic        pclk,
	// APB master side.
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic       [7:0] paddr,
	output logic      [31:0] pwdata,
	output logic       [3:0] pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// The request is held until pready is seen, so a slow slave is served as well.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic setup_step;
		logic [31:0] r;
		logic        e;
		xfer(1'b1, 8'h10, 32'h80, 4'hF, r, e);
	endtask
endmodule // fcc_apb_host

/* File: verif/fcc_config_regs_monitor.sv */
// Checker for the register bank's bus, pin and speed-reading behaviour.
`timescale 1ns/1ps

module fcc_config_regs_monitor #(
	parameter logic [3:0] REVISION = 4'h5
) (
	// Clock, reset and bus.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic  [7:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic  [3:0] pstrb,
	input  wire logic [31:0] prdata,
	// Pins and fan side.
	input  wire logic        thermal_alarm_pin_i,
	input  wire logic        thermal_alarm_pin_oe,
	input  wire logic        overtemp_condition,
	input  wire logic        overtemp_output_pin_n_o,
	input  wire logic        overtemp_output_pin_n_oe,
	input  wire logic        fan_full_speed,
	input  wire logic        setup_mode,
	input  wire logic        fan_speed_update
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_enable_oe: assert property (psel && penable && pwrite && pstrb[0] && paddr == 8'h10
		|-> ##2 overtemp_output_pin_n_oe == $past(pwdata[4], 2)) else $error("Overtemp enable not applied.");
	a_setup_bit: assert property (psel && penable && pwrite && pstrb[0] && paddr == 8'h10
		|-> ##2 setup_mode == $past(pwdata[7], 2)) else $error("Setup bit not applied.");
	a_revision_field: assert property (psel && penable && !pwrite && paddr == 8'hFC
		|-> prdata[3:0] == REVISION) else $error("Revision field wrong.");
	a_alarm_reserved: assert property (psel && penable && !pwrite && paddr == 8'hFC
		|-> prdata[6:4] == 3'h0 && prdata[31:8] == 24'h0) else $error("Alarm reserved bits wrong.");
	a_fan_speed_pulse_input_reserved: assert property (psel && penable && !pwrite && paddr == 8'h10
		|-> prdata[3:0] == 4'h8) else $error("Fan_speed_pulse_input reserved bits wrong.");
	a_outside_force: assert property ((!thermal_alarm_pin_oe && !thermal_alarm_pin_i)[*6]
		|=> fan_full_speed) else $error("Outside alarm did not force full speed.");
	a_no_force: assert property ((!thermal_alarm_pin_oe && thermal_alarm_pin_i)[*6]
		|=> !fan_full_speed) else $error("Full speed without alarm.");
	a_overtemp_level: assert property (overtemp_condition
		|=> !overtemp_output_pin_n_o) else $error("Overtemp pin not low.");
	a_update_gap: assert property (fan_speed_update
		|=> !fan_speed_update[*8]) else $error("Speed updates too close.");
endmodule // fcc_config_regs_monitor

bind fcc_config_regs fcc_config_regs_monitor #(.REVISION(REVISION)) fcc_config_regs_monitor_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .thermal_alarm_pin_i, .thermal_alarm_pin_oe,
	.overtemp_condition, .overtemp_output_pin_n_o, .overtemp_output_pin_n_oe, .fan_full_speed, .setup_mode,
	.fan_speed_update);

/* File: verif/test_fan_ctrl_config_regs.sv */
// Self-checking bench for the fan controller configuration bank.
`timescale 1ns/1ps

module test_fan_ctrl_config_regs;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ext_pull;
	logic        thermal_alarm_pin_i, thermal_alarm_pin_o, thermal_alarm_pin_oe, alarm_request;
	logic        overtemp_output_pin_n_o, overtemp_output_pin_n_oe, overtemp_condition;
	logic        fan_speed_pulse_input, fan_full_speed, setup_mode, fan_speed_update;
	logic  [7:0] paddr, fan_speed_pulse_input_m;
	logic  [3:0] pstrb;
	logic [31:0] pwdata, prdata, r, d;
	logic [15:0] fan_speed_reading;
	int          bad_count, comparisons, seed, i, n, cyc, expv;
	fcc_config_regs #(.FAST_CYC(40), .SLOW_CYC(160)) fcc_config_regs_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .thermal_alarm_pin_i, .thermal_alarm_pin_o,
		.thermal_alarm_pin_oe, .overtemp_output_pin_n_o, .overtemp_output_pin_n_oe, .fan_speed_pulse_input,
		.alarm_request, .overtemp_condition, .fan_full_speed, .setup_mode, .fan_speed_reading, .fan_speed_update);
	fcc_apb_host fcc_apb_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr);
	// The alarm line has a pull-up; either party may pull it low.
	assign thermal_alarm_pin_i = (thermal_alarm_pin_oe ? thermal_alarm_pin_o : 1'b1) & ~ext_pull;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		fcc_apb_host_inst.xfer(1'b0, a, 32'h0, 4'hF, r, er);
		chk(nm, e, r);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		fcc_apb_host_inst.xfer(1'b1, a, {24'h0, v}, 4'hF, r, er);
	endtask
	task automatic wait_upd;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (fan_speed_update !== 1'b1 && n < 400);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// A fan_speed_pulse_input edge every 8 cycles puts a fixed pulse count in every update window.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		fan_speed_pulse_input <= cyc[2];
		overtemp_condition <= 1'($random(seed));
		if (cyc == 20000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		seed = 19325;
		cyc = 0;
		presetn = 1'b0;
		alarm_request = 1'b0;
		ext_pull = 1'b0;
		overtemp_condition = 1'b0;
		fan_speed_pulse_input = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h10, 32'h08, "fan_speed_pulse_input reset");
		rd(8'hFC, {24'h0, 4'h8, fcc_pkg::REVISION_DEFAULT}, "alarm reset");
		fcc_apb_host_inst.setup_step;
		for (i = 0; i < 12; i++) begin
			d = $random(seed);
			wr(8'h10, {1'b1, d[6:0]});
			fan_speed_pulse_input_m = {1'b1, d[6:4], 4'h8};
			rd(8'h10, {24'h0, fan_speed_pulse_input_m}, "fan_speed_pulse_input reg");
			chk("overtemp oe", fan_speed_pulse_input_m[4], overtemp_output_pin_n_oe);
			chk("setup", fan_speed_pulse_input_m[7], setup_mode);
			wr(8'hFC, d[15:8]);
			rd(8'hFC, {24'h0, d[15], 3'h0, fcc_pkg::REVISION_DEFAULT}, "alarm reg");
		end
		fcc_apb_host_inst.xfer(1'b1, 8'h10, 32'hFF, 4'h0, r, er);
		rd(8'h10, {24'h0, fan_speed_pulse_input_m}, "masked write");
		fcc_apb_host_inst.xfer(1'b0, 8'h44, 32'h0, 4'hF, r, er);
		chk("unmapped err", 1, er);
		$display("register tests done");
		for (i = 0; i < 2; i++) begin
			wr(8'hFC, i[0] ? 8'h80 : 8'h00);
			alarm_request <= 1'b1;
			repeat (4) @(posedge pclk);
			chk("own alarm", i[0], fan_full_speed);
			alarm_request <= 1'b0;
			repeat (8) @(posedge pclk);
		end
		wr(8'hFC, 8'h00);
		ext_pull <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("outside alarm", 1, fan_full_speed);
		ext_pull <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("alarm gone", 0, fan_full_speed);
		$display("alarm tests done");
		for (i = 0; i < 4; i++) begin
			wr(8'h10, {1'b1, i[0], i[1], 5'h00});
			expv = ((i[1] ? 5 : 20) >> (i[0] ? 2 : 1)) * (i[1] ? 240 : 60);
			wait_upd;
			wait_upd;
			chk("period", i[1] ? 40 : 160, n);
			chk("reading", expv, fan_speed_reading);
			rd(8'h80, expv, "speed reg");
		end
		$display("speed tests done");
		print_verdict;
	end
endmodule // test_fan_ctrl_config_regs
